//--- design/eewp_pkg.sv
// Shared constants and types of the two-wire EEPROM write-protect slave.
// Assumes a 10 MHz system clock; all pin-level timing is counted in it.
package eewp_pkg;
  // ==========================================================
  // Clock and program-cycle timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_WR_MS = 10;
  localparam int T_WR_LONG_MS = 20;
  // Longest times round down so the cycle never overruns
  localparam int WR_CYCLES = (T_WR_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WR_LONG_CYCLES = (T_WR_LONG_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TMR_W = 18;

  // ==========================================================
  // Select byte and addressing
  // Device-type code: value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h6;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [10:0] PTR_ADDR = 11'h7ff;
  localparam logic [7:0] PTR_RESET = 8'hff;
  localparam int PROT_FLAG_BIT = 2;
  localparam logic PROT_FLAG_ON = 1'b0;
  localparam logic PROT_UPPER_HALF = 1'b1;
  localparam logic [3:0] ROW_FIRST = 4'h0;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam logic [3:0] ROW_STEP = 4'h1;

  // ==========================================================
  // Write latch ring
  localparam int BUF_AW = 4;
  localparam logic [4:0] BUF_DEPTH = 5'h10;

  // ==========================================================
  // Bus engine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b011,
    ST_WAIT = 3'b010,
    ST_PROG = 3'b110
  } eewp_state_t;

  typedef enum logic [1:0] {
    K_SEL  = 2'h0,
    K_ADDR = 2'h1,
    K_DATA = 2'h3
  } eewp_kind_t;
endpackage

//--- design/eewp_prog_timer.sv
// Self-timed program-cycle counter.
// Assumes start is a one-cycle pulse issued only while idle.
`timescale 1ns/1ps
module eewp_prog_timer #(
  parameter int SHORT_CYCLES = eewp_pkg::WR_CYCLES,
  parameter int LONG_CYCLES  = eewp_pkg::WR_LONG_CYCLES
) (
  input  wire logic clk,          // System clock
  input  wire logic rst,          // Asynchronous reset, high
  eewp_tmr_if.tmr   t             // Control handshake
);
  logic [eewp_pkg::TMR_W-1:0] cnt;
  logic [eewp_pkg::TMR_W-1:0] next_cnt;
  logic                       next_done;

  // ==========================================================
  // Count down from the chosen length
  always_comb
  begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (t.start)
      next_cnt = t.long_cycle ? eewp_pkg::TMR_W'(LONG_CYCLES - 1)
                              : eewp_pkg::TMR_W'(SHORT_CYCLES - 1);
    else if (cnt != '0)
    begin
      next_cnt = cnt - eewp_pkg::TMR_W'(1);
      next_done = (cnt == eewp_pkg::TMR_W'(1));
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt    <= '0;
      t.done <= 1'b0;
    end
    else
    begin
      cnt    <= next_cnt;
      t.done <= next_done;
    end
  end

  assign t.busy = (cnt != '0);
endmodule

//--- design/eewp_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are quasi-static levels or slow bus lines.
`timescale 1ns/1ps
module eewp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,  // System clock
  input  wire logic         rst,  // Asynchronous reset, high
  input  wire logic [W-1:0] d,    // Raw pin levels
  output logic      [W-1:0] q     // Synchronised levels
);
  logic [W-1:0] meta;

  // ==========================================================
  // First stage feeds only the second; both stages reset low, then follow the pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

//--- design/eewp_tmr_if.sv
// Handshake between the bus engine and the program-cycle timer.
// Both ends run on the same system clock.
`timescale 1ns/1ps
interface eewp_tmr_if;
  logic start;       // One-cycle request to begin a program cycle
  logic long_cycle;  // Use the doubled write time
  logic busy;        // Cycle running
  logic done;        // One-cycle pulse at cycle end
  modport ctl (output start, output long_cycle, input busy, input done);
  modport tmr (input start, input long_cycle, output busy, output done);
endinterface

//--- design/eewp_top.sv
// Two-wire serial EEPROM slave: 8 blocks of 256 bytes, write modes,
// self-timed program cycle, write inhibit and block write protection.
// Assumes the bus master drives scl; all pins are asynchronous to clk.
//
// Function
// (RQ1) START: data falls while clock high
// (RQ2) Ignore bus until START, outside programming
// (RQ3) STOP: data rises while clock high; ends
// (RQ4) STOP after read returns to standby
// (RQ5) STOP after write starts program cycle
// (RQ6) Release after 8 bits; ack ninth
// (RQ7) Sample data on clock rising edge
// (RQ8) Select byte: type, block, direction
// (RQ9) Acknowledge 8-bit byte address in block
// (RQ10) Mode pin picks multibyte or page
// (RQ11) Inhibit high until address: no data ack
// (RQ12) Byte write: one byte, any mode
// (RQ13) Multibyte: one to eight bytes, any start
// (RQ14) Multibyte cycle 10 ms, 20 across rows
// (RQ15) Master sends at most eight multibyte bytes
// (RQ16) Page: sixteen bytes, low nibble wraps
// (RQ17) Inputs disabled during program cycle
// (RQ18) Ack polling: no ack while programming
// (RQ19) Protected from boundary to top address
// (RQ20) Pointer upper nibble gives 16-byte boundary
// (RQ21) Two pins select protected block four-seven
// (RQ22) Protect needs enable pin and flag zero
// (RQ23) Multibyte below boundary leaks seven bytes
// (RQ24) Inhibit variant has no multibyte write
// (RQ25) Unconnected inhibit input reads low
// (RQ26) Bus lines synchronised; events from samples
// (RQ27) Cycle length from counter, within maximum
`timescale 1ns/1ps
module eewp_top #(
  parameter bit WI_VARIANT     = 1'b0,
  parameter int SHORT_CYCLES   = eewp_pkg::WR_CYCLES,
  parameter int LONG_CYCLES    = eewp_pkg::WR_LONG_CYCLES
) (
  input  wire logic clk,                  // System clock, 10 MHz
  input  wire logic rst,                  // Asynchronous reset, high
  input  wire logic scl,                  // Serial clock from master
  input  wire logic sda_in,               // Serial data line level
  output logic      sda_out,              // Serial data drive value
  output logic      sda_oe,               // Serial data drive enable
  input  wire logic mode_pin,             // High multibyte, low page
  input  wire logic write_inhibit_pin,    // High blocks writes
  input  wire logic protect_enable_pin,   // High arms protection
  input  wire logic protect_block_sel_lo, // Protected block select, low
  input  wire logic protect_block_sel_hi, // Protected block select, high
  output logic      prog_busy             // Program cycle running
);
  // ==========================================================
  // Pin synchronisation
  logic [6:0] pins_s;
  logic s_scl, s_sda, s_mode, s_wi, s_pre, s_pb_lo, s_pb_hi;
  logic p_scl, p_sda;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  eewp_sync #(.W(7)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({scl, sda_in, mode_pin, write_inhibit_pin, protect_enable_pin,
           protect_block_sel_lo, protect_block_sel_hi}), // RQ26
    .q   (pins_s)
  );
  assign {s_scl, s_sda, s_mode, s_wi, s_pre, s_pb_lo, s_pb_hi} = pins_s;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      p_scl <= 1'b0;
      p_sda <= 1'b0;
    end
    else
    begin
      p_scl <= s_scl;
      p_sda <= s_sda;
    end
  end

  assign scl_rise = s_scl & ~p_scl;
  assign scl_fall = ~s_scl & p_scl;
  assign start_ev = s_scl & p_scl & p_sda & ~s_sda; // RQ1
  assign stop_ev  = s_scl & p_scl & ~p_sda & s_sda; // RQ3

  // ==========================================================
  // Program timer
  eewp_tmr_if tmr ();

  eewp_prog_timer #(
    .SHORT_CYCLES (SHORT_CYCLES),
    .LONG_CYCLES  (LONG_CYCLES)
  ) u_tmr (
    .clk (clk),
    .rst (rst),
    .t   (tmr.tmr)
  );

  // ==========================================================
  // Storage
  logic [7:0]  mem      [0:2047];
  logic [10:0] buf_addr [0:15];
  logic [7:0]  buf_data [0:15];

  // ==========================================================
  // Engine state
  eewp_pkg::eewp_state_t state, next_state;
  eewp_pkg::eewp_kind_t  kind, next_kind;
  logic [3:0]  bitcnt, next_bitcnt;
  logic [7:0]  shreg, next_shreg;
  logic        rw, next_rw;
  logic [2:0]  blk, next_blk;
  logic [7:0]  baddr, next_baddr;
  logic [3:0]  start_row, next_start_row;
  logic        multi, next_multi;
  logic        inhibit, next_inhibit;
  logic        prot, next_prot;
  logic        span, next_span;
  logic [4:0]  nbytes, next_nbytes;
  logic [3:0]  widx, next_widx;
  logic [4:0]  cidx, next_cidx;
  logic        next_sda_oe;
  logic [7:0]  protect_boundary_pointer, next_ptr;
  logic        buf_we, mem_we;
  logic [10:0] mem_wa, boundary, addr_now;
  logic [7:0]  mem_wd;
  logic        prot_on;

  // Protection is armed by the pin and a cleared flag bit
  assign prot_on  = s_pre &&
                    (protect_boundary_pointer[eewp_pkg::PROT_FLAG_BIT] == eewp_pkg::PROT_FLAG_ON); // RQ22
  assign boundary = {eewp_pkg::PROT_UPPER_HALF, s_pb_hi, s_pb_lo,
                     protect_boundary_pointer[7:4], eewp_pkg::ROW_FIRST}; // RQ20 RQ21
  assign addr_now = {blk, shreg};
  assign mem_wa   = buf_addr[cidx[3:0]];
  assign mem_wd   = buf_data[cidx[3:0]];

  always_comb
  begin
    next_state     = state;
    next_kind      = kind;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_rw        = rw;
    next_blk       = blk;
    next_baddr     = baddr;
    next_start_row = start_row;
    next_multi     = multi;
    next_inhibit   = inhibit;
    next_prot      = prot;
    next_span      = span;
    next_nbytes    = nbytes;
    next_widx      = widx;
    next_cidx      = cidx;
    next_ptr       = protect_boundary_pointer;
    buf_we         = 1'b0;
    mem_we         = 1'b0;
    tmr.start      = 1'b0;
    tmr.long_cycle = span; // RQ14
    // Inhibit is caught at any time from START to end of address
    if (WI_VARIANT && state != eewp_pkg::ST_PROG && kind != eewp_pkg::K_DATA)
      next_inhibit = inhibit | s_wi; // RQ11 RQ25
    unique case (state)
      eewp_pkg::ST_IDLE,
      eewp_pkg::ST_WAIT:
      begin
      end
      eewp_pkg::ST_RX:
      begin
        if (scl_rise)
        begin
          next_shreg  = {shreg[6:0], s_sda}; // RQ7
          next_bitcnt = bitcnt + 4'h1;
        end
        else if (scl_fall && bitcnt == eewp_pkg::BITS_PER_BYTE)
        begin
          next_bitcnt = '0;
          next_state  = eewp_pkg::ST_ACK; // RQ6
          unique case (kind)
            eewp_pkg::K_SEL:
            begin
              next_rw  = shreg[0]; // RQ8
              next_blk = shreg[3:1];
              if (shreg[7:4] != eewp_pkg::DEV_TYPE)
                next_state = eewp_pkg::ST_WAIT;
            end
            eewp_pkg::K_ADDR:
            begin
              next_baddr     = shreg; // RQ9
              next_start_row = shreg[7:4];
              next_multi     = s_mode && !WI_VARIANT; // RQ10 RQ24
              // Only the start address is checked, so a multibyte
              // run can spill past the boundary
              next_prot      = prot_on && (addr_now >= boundary); // RQ19 RQ23
            end
            default:
            begin
              if (inhibit)
                next_state = eewp_pkg::ST_WAIT; // RQ11
              else
              begin
                buf_we    = 1'b1; // RQ12 RQ13
                next_widx = widx + 4'h1;
                if (nbytes != eewp_pkg::BUF_DEPTH)
                  next_nbytes = nbytes + 5'h1;
                if (multi)
                begin
                  next_baddr = baddr + eewp_pkg::ADDR_STEP;
                  if (baddr[7:4] != start_row)
                    next_span = 1'b1; // RQ14
                end
                else
                  next_baddr = {baddr[7:4], baddr[3:0] + eewp_pkg::ROW_STEP}; // RQ16
              end
            end
          endcase
        end
      end
      eewp_pkg::ST_ACK:
      begin
        if (scl_fall)
        begin
          if (kind == eewp_pkg::K_SEL && rw)
            next_state = eewp_pkg::ST_WAIT;
          else
          begin
            next_state = eewp_pkg::ST_RX;
            next_kind  = (kind == eewp_pkg::K_SEL) ? eewp_pkg::K_ADDR : eewp_pkg::K_DATA;
          end
        end
      end
      eewp_pkg::ST_PROG:
      begin
        // Commit the latched bytes while the timer runs
        if (cidx < nbytes)
        begin
          mem_we    = ~prot; // RQ19
          next_cidx = cidx + 5'h1;
          if (!prot && mem_wa == eewp_pkg::PTR_ADDR)
            next_ptr = mem_wd; // RQ20
        end
        if (tmr.done)
          next_state = eewp_pkg::ST_IDLE; // RQ27
      end
      default:
        next_state = eewp_pkg::ST_IDLE;
    endcase
    // Bus conditions override everything except the program cycle
    if (state != eewp_pkg::ST_PROG) // RQ17 RQ18
    begin
      if (start_ev)
      begin
        next_state   = eewp_pkg::ST_RX; // RQ2
        next_kind    = eewp_pkg::K_SEL;
        next_bitcnt  = '0;
        next_rw      = 1'b0;
        next_span    = 1'b0;
        next_nbytes  = '0;
        next_widx    = '0;
        next_inhibit = WI_VARIANT && s_wi;
      end
      else if (stop_ev)
      begin
        if (!rw && nbytes != '0 && !inhibit)
        begin
          next_state = eewp_pkg::ST_PROG; // RQ5
          tmr.start  = 1'b1;
          next_cidx  = '0;
        end
        else
          next_state = eewp_pkg::ST_IDLE; // RQ3 RQ4
      end
    end
    next_sda_oe = (next_state == eewp_pkg::ST_ACK); // RQ6
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state                    <= eewp_pkg::ST_IDLE;
      kind                     <= eewp_pkg::K_SEL;
      bitcnt                   <= '0;
      shreg                    <= '0;
      rw                       <= 1'b0;
      blk                      <= '0;
      baddr                    <= '0;
      start_row                <= '0;
      multi                    <= 1'b0;
      inhibit                  <= 1'b0;
      prot                     <= 1'b0;
      span                     <= 1'b0;
      nbytes                   <= '0;
      widx                     <= '0;
      cidx                     <= '0;
      sda_oe                   <= 1'b0;
      protect_boundary_pointer <= eewp_pkg::PTR_RESET;
    end
    else
    begin
      state                    <= next_state;
      kind                     <= next_kind;
      bitcnt                   <= next_bitcnt;
      shreg                    <= next_shreg;
      rw                       <= next_rw;
      blk                      <= next_blk;
      baddr                    <= next_baddr;
      start_row                <= next_start_row;
      multi                    <= next_multi;
      inhibit                  <= next_inhibit;
      prot                     <= next_prot;
      span                     <= next_span;
      nbytes                   <= next_nbytes;
      widx                     <= next_widx;
      cidx                     <= next_cidx;
      sda_oe                   <= next_sda_oe;
      protect_boundary_pointer <= next_ptr;
    end
  end

  // ==========================================================
  // Array writes; no reset, the cells are nonvolatile in intent
  always_ff @(posedge clk)
  begin
    if (buf_we)
    begin
      buf_addr[widx] <= {blk, baddr};
      buf_data[widx] <= shreg;
    end
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // Open-drain: only ever pulls low
  assign sda_out   = 1'b0;
  assign prog_busy = (state == eewp_pkg::ST_PROG);
endmodule

//--- tb/eewp_chk.sv
// Pin-level assertions for the two-wire EEPROM slave.
// Assumes the master holds scl low 5 clk and high 3 clk per bit.
`timescale 1ns/1ps
module eewp_chk #(
  parameter int SHORT_CYCLES = 200,
  parameter int LONG_CYCLES  = 400
) (
  input wire logic clk,       // System clock
  input wire logic rst,       // Asynchronous reset, high
  input wire logic scl,       // Serial clock
  input wire logic sda_in,    // Resolved data line
  input wire logic sda_out,   // Data drive value
  input wire logic sda_oe,    // Data drive enable
  input wire logic prog_busy  // Program cycle running
);
  // ========
  // Busy-length counter
  int unsigned busy_cnt;
  int unsigned next_busy_cnt;
  always_comb next_busy_cnt = prog_busy ? busy_cnt + 1 : 0;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      busy_cnt <= 0;
    else
      busy_cnt <= next_busy_cnt;

  // ========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  AST_ACK_SCL_LOW: assert property ($changed(sda_oe) |-> !scl)
    else $error("ack edge while clock high");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe[*6])
    else $error("ack too short");
  AST_ACK_END: assert property ($rose(sda_oe) |-> ##[6:16] !sda_oe)
    else $error("ack not released");
  AST_BUSY_NO_ACK: assert property (prog_busy |-> !sda_oe)
    else $error("ack while programming");
  AST_BUSY_AFTER_STOP: assert property ($rose(prog_busy) |-> scl && sda_in)
    else $error("cycle began without stop");
  AST_BUSY_MIN: assert property ($fell(prog_busy) |-> busy_cnt >= SHORT_CYCLES)
    else $error("program cycle too short");
  AST_BUSY_MAX: assert property (busy_cnt <= LONG_CYCLES + 1)
    else $error("program cycle too long");
  AST_RESET_QUIET: assert property ($past(rst) |-> !sda_oe && !prog_busy)
    else $error("active straight after reset");

  cover property ($rose(sda_oe));
  cover property ($rose(prog_busy));
  cover property ($fell(prog_busy) && busy_cnt > SHORT_CYCLES + 2);
endmodule

bind eewp_top eewp_chk #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .prog_busy(prog_busy));

//--- tb/eewp_master.sv
// Behavioural two-wire bus master, stepped on the system clock.
// Assumes a pull-up on the data line; sda_low pulls it down.
`timescale 1ns/1ps
module eewp_master (
  input  wire logic clk,    // System clock
  input  wire logic sda,    // Resolved data line
  output logic      scl,    // Serial clock drive
  output logic      sda_low // Pull data low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data moves only in the low half; 800 ns per bit
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_low <= !b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda;
    scl <= 1'b0;
  endtask

  task automatic start;
    tick(2);
    sda_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b0;
  endtask

  task automatic stop;
    tick(2);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b0;
    tick(6);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
endmodule

//--- tb/serial_eeprom_write_protect_slave_bench.sv
// Self-checking bench for the two-wire EEPROM write-protect slave.
// Assumes the array is visible as uut.mem for read-back.
`timescale 1ns/1ps
module serial_eeprom_write_protect_slave_bench;
  localparam int SHORT = 200;
  localparam int LONG  = 400;
  logic       clk = 1'b0;
  logic       rst;
  logic       mode;
  logic       winh;
  logic       pe;
  logic [1:0] pb;
  logic       scl;
  logic       m_low;
  logic       sda_out;
  logic       sda_oe;
  logic       prog_busy;
  wire        sda = !(m_low || (sda_oe && !sda_out));
  logic       scl_w;
  logic       m_low_w;
  logic       sda_out_w;
  logic       sda_oe_w;
  logic       busy_w;
  wire        sda_w = !(m_low_w || (sda_oe_w && !sda_out_w));
  int         n_mismatch = 0;
  int         checks_done = 0;

  always #50 clk = ~clk;

  eewp_top #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) uut (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .mode_pin(mode), .write_inhibit_pin(winh), .protect_enable_pin(pe),
    .protect_block_sel_lo(pb[0]), .protect_block_sel_hi(pb[1]), .prog_busy(prog_busy));
  eewp_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

  // Write-inhibit variant needs its own instance and bus
  eewp_top #(.WI_VARIANT(1'b1), .SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) uut_wi (
    .clk(clk), .rst(rst), .scl(scl_w), .sda_in(sda_w), .sda_out(sda_out_w), .sda_oe(sda_oe_w),
    .mode_pin(mode), .write_inhibit_pin(winh), .protect_enable_pin(pe),
    .protect_block_sel_lo(pb[0]), .protect_block_sel_hi(pb[1]), .prog_busy(busy_w));
  eewp_master m_wi (.clk(clk), .sda(sda_w), .scl(scl_w), .sda_low(m_low_w));

  // ========
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // At most eight data bytes per command
  task automatic wr(input logic [2:0] blk, input logic [7:0] a, input int n, input logic [7:0] d0);
    logic ack;
    m.start();
    m.wbyte({eewp_pkg::DEV_TYPE, blk, 1'b0}, ack);
    check(ack, 1'b1);
    m.wbyte(a, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.wbyte(d0 + 8'(i), ack);
      check(ack, 1'b1);
    end
    m.stop();
    check(prog_busy, 1'b1);
  endtask

  task automatic wait_idle(output int c);
    c = 0;
    while (prog_busy === 1'b1 && c < 1000)
    begin
      @(posedge clk);
      c++;
    end
    check(prog_busy, 1'b0);
  endtask

  // ========
  // Scenarios
  task automatic t_reject;
    logic ack;
    m.start();
    m.wbyte({eewp_pkg::DEV_TYPE ^ 4'h1, 3'h0, 1'b0}, ack);
    check(ack, 1'b0);
    m.stop();
    check(prog_busy, 1'b0);
    m.start();
    m.wbyte({eewp_pkg::DEV_TYPE, 3'h0, 1'b1}, ack);
    check(ack, 1'b1);
    m.stop();
    check(prog_busy, 1'b0);
  endtask

  task automatic t_byte_poll;
    logic ack;
    int   c;
    @(posedge clk) mode <= 1'b0;
    wr(3'h2, 8'h35, 1, 8'ha5);
    m.start();
    m.wbyte({eewp_pkg::DEV_TYPE, 3'h2, 1'b0}, ack);
    check(ack, 1'b0);
    m.stop();
    wait_idle(c);
    check(c <= SHORT + 1, 1'b1);
    m.start();
    m.wbyte({eewp_pkg::DEV_TYPE, 3'h2, 1'b0}, ack);
    check(ack, 1'b1);
    m.stop();
    check(prog_busy, 1'b0);
    check(uut.mem[11'h235], 8'ha5);
  endtask

  task automatic t_page;
    int c;
    @(posedge clk) mode <= 1'b0;
    wr(3'h1, 8'h1e, 4, 8'h10);
    wait_idle(c);
    check(uut.mem[11'h11f], 8'h11);
    check(uut.mem[11'h110], 8'h12);
  endtask

  task automatic t_multi;
    int c;
    @(posedge clk) mode <= 1'b1;
    wr(3'h3, 8'h1c, 6, 8'h20);
    wait_idle(c);
    check(c > SHORT + 1, 1'b1);
    check(uut.mem[11'h321], 8'h25);
  endtask

  task automatic t_protect;
    int c;
    @(posedge clk)
    begin
      mode <= 1'b0;
      pe <= 1'b0;
      pb <= 2'b11;
    end
    wr(3'h7, 8'h90, 1, 8'h11);
    wait_idle(c);
    wr(3'h4, 8'h90, 1, 8'h44);
    wait_idle(c);
    wr(3'h7, 8'hff, 1, 8'h80);
    wait_idle(c);
    @(posedge clk) pe <= 1'b1;
    wr(3'h7, 8'h90, 1, 8'h55);
    wait_idle(c);
    check(uut.mem[11'h790], 8'h11);
    wr(3'h7, 8'h70, 1, 8'h66);
    wait_idle(c);
    check(uut.mem[11'h770], 8'h66);
    @(posedge clk) mode <= 1'b1;
    wr(3'h7, 8'h7f, 3, 8'ha0);
    wait_idle(c);
    check(uut.mem[11'h781], 8'ha2);
    @(posedge clk)
    begin
      mode <= 1'b0;
      pb <= 2'b00;
    end
    wr(3'h4, 8'h90, 1, 8'h77);
    wait_idle(c);
    check(uut.mem[11'h490], 8'h44);
    @(posedge clk) pe <= 1'b0;
    wr(3'h7, 8'h90, 1, 8'h88);
    wait_idle(c);
    check(uut.mem[11'h790], 8'h88);
    wr(3'h7, 8'hff, 1, 8'h84);
    wait_idle(c);
    @(posedge clk) pe <= 1'b1;
    wr(3'h4, 8'h90, 1, 8'h99);
    wait_idle(c);
    check(uut.mem[11'h490], 8'h99);
  endtask

  task automatic t_inhibit;
    logic ack;
    int   c;
    @(posedge clk)
    begin
      mode <= 1'b1;
      winh <= 1'b1;
    end
    m_wi.start();
    m_wi.wbyte({eewp_pkg::DEV_TYPE, 3'h5, 1'b0}, ack);
    check(ack, 1'b1);
    m_wi.wbyte(8'h0f, ack);
    check(ack, 1'b1);
    m_wi.wbyte(8'h3c, ack);
    check(ack, 1'b0);
    m_wi.stop();
    check(busy_w, 1'b0);
    @(posedge clk) winh <= 1'b0;
    m_wi.start();
    m_wi.wbyte({eewp_pkg::DEV_TYPE, 3'h5, 1'b0}, ack);
    check(ack, 1'b1);
    m_wi.wbyte(8'h0f, ack);
    check(ack, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      m_wi.wbyte(8'hc1 + 8'(i), ack);
      check(ack, 1'b1);
    end
    m_wi.stop();
    check(busy_w, 1'b1);
    c = 0;
    while (busy_w === 1'b1 && c < 1000)
    begin
      @(posedge clk);
      c++;
    end
    check(busy_w, 1'b0);
    check(c <= SHORT + 1, 1'b1);
    check(uut_wi.mem[11'h50f], 8'hc1);
    check(uut_wi.mem[11'h500], 8'hc2);
  endtask

  // ========
  // Sequence and verdict
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    mode = 1'b0;
    winh = 1'b0;
    pe = 1'b0;
    pb = 2'b00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reject();
    t_byte_poll();
    t_page();
    t_multi();
    t_protect();
    t_inhibit();
    conclude();
  end

  // Whole run needs about 8000 cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule
